// *** sprs_pkg.sv ***
// Package for the system protection and reset status block.
// Assumes a simple strobe register port and a single system clock domain.
package sprs_pkg;
	// Register offsets on the local register port.
	localparam logic [3:0] OFF_RESET_CAUSE  = 4'h0;
	localparam logic [3:0] OFF_WDOG_VECTOR  = 4'h1;
	localparam logic [3:0] OFF_PROT_CONTROL = 4'h2;
	localparam logic [3:0] OFF_WDOG_SERVICE = 4'h3;
	localparam logic [3:0] OFF_WDOG_PRESCALE = 4'h4;

	// Reset cause bit positions; bit 3 is reserved.
	localparam int RC_HARD     = 7;
	localparam int RC_POWER    = 6;
	localparam int RC_WATCHDOG = 5;
	localparam int RC_DBLFAULT = 4;
	localparam int RC_CLKLOSS  = 2;
	localparam int RC_RSTINSTR = 1;
	localparam int RC_SOFTPIN  = 0;
	localparam logic [7:0] RC_IMPL_MASK = 8'hF7;

	// Protection control field positions.
	localparam int PC_WDOG_ENABLE = 7;
	localparam int PC_WDOG_ACTION = 6;
	localparam int PC_WDOG_TIM_HI = 5;
	localparam int PC_WDOG_TIM_LO = 4;
	localparam int PC_DBLF_ENABLE = 3;
	localparam int PC_BMON_DISABLE = 2;
	localparam int PC_BMON_TIM_HI = 1;
	localparam int PC_BMON_TIM_LO = 0;
	localparam logic [7:0] PC_RESET = 8'hFF;

	localparam logic [7:0] WDOG_VECTOR_RESET = 8'h0F;
	localparam logic [7:0] SERVICE_FIRST  = 8'h55;
	localparam logic [7:0] SERVICE_SECOND = 8'hAA;

	// Timeout exponents: unprescaled 2^9..2^15, prescaled adds 2^9 (divide by 512).
	localparam int WDOG_EXP_BASE  = 9;
	localparam int WDOG_EXP_STEP  = 2;
	localparam int WDOG_EXP_PRESC = 9;
	localparam int XTAL_DIV_SLOW  = 128;
	localparam int BMON_MAX_CYCLES = 1024;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'b01,
		SVC_ARMED = 2'b10
	} sprs_svc_type;
endpackage

// *** sprs_protect.sv ***
// System protection and reset status: watchdog, bus monitor, reset cause flags.
// Assumes reset sources are pulses from the reset controller, held until the reset completes.
// How it works
// - Reset cause flags update when a reset completes, adding its causes to the flags already set.
// - Power-on reset leaves both power-on and hard reset flags set.
// - Flags clear on power-on or writing one; zero writes keep them.
// - Separate flags for every reset source; bit three reads zero.
// - Clock loss reset needs loss enable and oscillator loop enable.
// - Reset instruction flag is meaningless while the processor is disabled.
// - Watchdog vector register returned at acknowledge, soft_reset_pin to fifteen.
// - Protection control accepts only the first write after system reset.
// - Watchdog enable bit gates the watchdog, set after reset.
// - Expiry gives level seven interrupt or system reset per action bit.
// - Timeout is two to nine..fifteen, or eighteen..twenty-four prescaled.
// - Watchdog timing field soft_reset_pin to the longest setting.
// - Watchdog input clock is crystal divided by one or 128 per mode pins.
// - New timeout takes effect only after the full service sequence.
// - Double fault monitor active while its enable bit is one.
// - Bus monitor runs when its control bit is zero, off by default.
// - Bus monitor timeout is 1024, 512, 256 or 128 clocks.
// - Service is 0x55 then 0xAA; the service register reads zero.
// - Prescale divides the watchdog clock by 512 before counting.
module sprs_protect
	import sprs_pkg::*;
#(
	parameter int WDOG_CNT_W = 25  // Watchdog counter width, covers 2^24.
) (
	input  wire logic       clk_sys,          // System clock, 50 MHz.
	input  wire logic       sys_rst,          // Synchronous system reset, active high.
	input  wire logic [3:0] regAddr,          // Register address.
	input  wire logic [7:0] regWrData,        // Register write data.
	input  wire logic       regWrite,         // Write strobe.
	input  wire logic       regRead,          // Read strobe.
	output logic      [7:0] regRdData,        // Read data, one cycle after the strobe.
	input  wire logic       xtalTick,         // One pulse per crystal clock, system domain.
	input  wire logic [1:0] clock_mode_pins,  // Mode clock pins, asynchronous.
	input  wire logic       rstDone,          // Pulse: reset sequence completed.
	input  wire logic       powerOnRst,       // Pulse: power-on reset occurred.
	input  wire logic       hardRst,          // Pulse: hard reset pin reset occurred.
	input  wire logic       dblFaultRst,      // Pulse: double bus fault reset occurred.
	input  wire logic       clkLossRst,       // Pulse: reference clock loss detected.
	input  wire logic       clock_loss_reset_enable, // Clock unit reset-on-loss enable.
	input  wire logic       oscLoopEnable,    // Oscillator loop enabled.
	input  wire logic       rstInstrRst,      // Pulse: processor reset instruction reset.
	input  wire logic       cpuDisabled,      // Processor disabled mode.
	input  wire logic       softPinRst,       // Pulse: soft reset pin reset occurred.
	input  wire logic       dblFaultSeen,     // Processor reports a double bus fault.
	input  wire logic       extCycleActive,   // External bus cycle in progress.
	input  wire logic       extCycleDone,     // External cycle terminated normally.
	input  wire logic       irqAck,           // Acknowledge cycle for the watchdog interrupt.
	output logic      [7:0] irqVector,        // Vector placed on the bus during acknowledge.
	output logic            wdogIrqL7,        // Level 7 watchdog interrupt request.
	output logic            wdogRstReq,       // Pulse: watchdog requests a system reset.
	output logic            dblFaultRstReq,   // Level: monitor requests a double fault reset while dblFaultSeen is high and its enable bit is set.
	output logic            clkLossRstReq,    // Pulse: clock loss reset request.
	output logic            busError          // Pulse: bus monitor ends the cycle.
);
	// Elaboration check: a narrow counter would wrap before the longest limit.
	if (WDOG_CNT_W < WDOG_EXP_PRESC + WDOG_EXP_BASE + 3 * WDOG_EXP_STEP + 1) begin : g_bad_width
		$error("sprs_protect: watchdog counter too narrow");
	end

	localparam int PRE_W = WDOG_EXP_PRESC;
	localparam int XD_W = $clog2(XTAL_DIV_SLOW);
	localparam int BM_W = $clog2(BMON_MAX_CYCLES) + 1;

	typedef struct packed {
		logic [7:0]            cause;
		logic [7:0]            vector;
		logic [7:0]            ctrl;
		logic                  ctrlLocked;
		logic                  prescale;
		logic [1:0]            activeTim;
		logic                  activePre;
		sprs_svc_type          svc;
		logic [WDOG_CNT_W-1:0] wdCnt;
		logic [PRE_W-1:0]      preCnt;
		logic [XD_W-1:0]       xdCnt;
		logic                  irq;
		logic                  rstReq;
		logic [BM_W-1:0]       bmCnt;
		logic                  berr;
		logic [7:0]            rdData;
		logic [7:0]            pendCause;
		logic [1:0]            modeA;
		logic [1:0]            modeB;
		logic                  slowDiv;
		logic                  strapPending;
	} sprs_state_type;

	sprs_state_type st_q, st_d;

	// Decodes the watchdog limit from the timing code; prescale is applied by the separate prescaler.
	function automatic logic [WDOG_CNT_W-1:0] wdLimit(input logic [1:0] tim);
		int exp;
		exp = WDOG_EXP_BASE + WDOG_EXP_STEP * int'(tim);
		return WDOG_CNT_W'(1) << exp;
	endfunction

	function automatic logic [BM_W-1:0] bmLimit(input logic [1:0] tim);
		return BM_W'(BMON_MAX_CYCLES) >> tim;
	endfunction

	logic wrHit, xdTick, wdTick, wdEnable, svcDone, bmEnable;

	always_comb begin
		st_d = st_q;
		st_d.rstReq = 1'b0;
		st_d.berr = 1'b0;
		st_d.rdData = 8'h00;
		wrHit = regWrite;
		wdEnable = st_q.ctrl[PC_WDOG_ENABLE];
		svcDone = 1'b0;
		bmEnable = 1'b0;
		// Mode pins pass two flops; the divide choice is caught one cycle after reset release.
		st_d.modeA = clock_mode_pins;
		st_d.modeB = st_q.modeA;
		if (st_q.strapPending) begin
			st_d.slowDiv = (st_q.modeB != 2'b00);
			st_d.prescale = ~st_q.modeB[1];
			st_d.activePre = ~st_q.modeB[1];
			st_d.strapPending = 1'b0;
		end

		xdTick = 1'b0;
		if (xtalTick) begin
			if (!st_q.slowDiv || st_q.xdCnt == XD_W'(XTAL_DIV_SLOW - 1)) begin
				xdTick = 1'b1;
				st_d.xdCnt = '0;
			end else begin
				st_d.xdCnt = st_q.xdCnt + XD_W'(1);
			end
		end

		wdTick = 1'b0;
		if (xdTick) begin
			if (!st_q.activePre) begin
				wdTick = 1'b1;
			end else begin
				st_d.preCnt = st_q.preCnt + PRE_W'(1);
				wdTick = (st_q.preCnt == '1);
			end
		end

		// Register writes.
		if (wrHit) begin
			unique case (regAddr)
				OFF_RESET_CAUSE: st_d.cause = st_q.cause & ~(regWrData & RC_IMPL_MASK);
				OFF_WDOG_VECTOR: st_d.vector = regWrData;
				OFF_PROT_CONTROL: begin
					if (!st_q.ctrlLocked) begin
						st_d.ctrl = regWrData;
						st_d.ctrlLocked = 1'b1;
					end
				end
				OFF_WDOG_SERVICE: begin
					if (regWrData == SERVICE_FIRST)
						st_d.svc = SVC_ARMED;
					else if (regWrData == SERVICE_SECOND && st_q.svc == SVC_ARMED) begin
						svcDone = 1'b1;
						st_d.svc = SVC_IDLE;
					end else
						st_d.svc = SVC_IDLE;
				end
				OFF_WDOG_PRESCALE: st_d.prescale = regWrData[0];
				default: ;
			endcase
		end

		if (svcDone) begin
			st_d.activeTim = st_q.ctrl[PC_WDOG_TIM_HI:PC_WDOG_TIM_LO];
			st_d.activePre = st_q.prescale;
			st_d.wdCnt = '0;
			st_d.preCnt = '0;
		end else if (!wdEnable) begin
			st_d.wdCnt = '0;
		end else if (wdTick) begin
			// Expiry at selected power of two
			if (st_q.wdCnt + WDOG_CNT_W'(1) >= wdLimit(st_q.activeTim)) begin
				st_d.wdCnt = '0;
				if (st_q.ctrl[PC_WDOG_ACTION])
					st_d.rstReq = 1'b1;
				else
					st_d.irq = 1'b1;
			end else begin
				st_d.wdCnt = st_q.wdCnt + WDOG_CNT_W'(1);
			end
		end
		if (irqAck)
			st_d.irq = 1'b0;

		bmEnable = ~st_q.ctrl[PC_BMON_DISABLE];
		if (!bmEnable || !extCycleActive || extCycleDone) begin
			st_d.bmCnt = '0;
		end else if (st_q.bmCnt == bmLimit(st_q.ctrl[PC_BMON_TIM_HI:PC_BMON_TIM_LO]) - BM_W'(1)) begin
			st_d.berr = 1'b1;
			st_d.bmCnt = '0;
		end else begin
			st_d.bmCnt = st_q.bmCnt + BM_W'(1);
		end

		// Reset causes gather until the reset sequence completes.
		if (hardRst)
			st_d.pendCause[RC_HARD] = 1'b1;
		if (powerOnRst) begin
			// Power-on starts the gathering afresh, so stale or unknown causes never survive it.
			st_d.pendCause = 8'h00;
			st_d.pendCause[RC_POWER] = 1'b1;
			st_d.pendCause[RC_HARD] = 1'b1;
		end
		if (st_q.rstReq)
			st_d.pendCause[RC_WATCHDOG] = 1'b1;
		if (dblFaultRst)
			st_d.pendCause[RC_DBLFAULT] = 1'b1;
		if (clkLossRst && clock_loss_reset_enable && oscLoopEnable)
			st_d.pendCause[RC_CLKLOSS] = 1'b1;
		if (rstInstrRst && !cpuDisabled)
			st_d.pendCause[RC_RSTINSTR] = 1'b1;
		if (softPinRst)
			st_d.pendCause[RC_SOFTPIN] = 1'b1;
		if (rstDone) begin
			st_d.cause = (st_d.pendCause & RC_IMPL_MASK) | (st_d.pendCause[RC_POWER] ? 8'h00 : st_d.cause);
			st_d.pendCause = 8'h00;
		end

		if (regRead) begin
			unique case (regAddr)
				OFF_RESET_CAUSE:   st_d.rdData = st_q.cause;
				OFF_WDOG_VECTOR:   st_d.rdData = st_q.vector;
				OFF_PROT_CONTROL:  st_d.rdData = st_q.ctrl;
				OFF_WDOG_SERVICE:  st_d.rdData = 8'h00;
				OFF_WDOG_PRESCALE: st_d.rdData = {7'h00, st_q.prescale};
				default:           st_d.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q.cause        <= st_d.cause;
			st_q.pendCause    <= st_d.pendCause;
			st_q.vector       <= WDOG_VECTOR_RESET;
			// Longest timings, bus monitor off, double fault monitor and watchdog on
			st_q.ctrl         <= PC_RESET & ~(8'h01 << PC_BMON_TIM_LO) & ~(8'h01 << PC_BMON_TIM_HI);
			st_q.ctrlLocked   <= 1'b0;
			st_q.prescale     <= 1'b0;
			st_q.activeTim    <= PC_RESET[PC_WDOG_TIM_HI:PC_WDOG_TIM_LO];
			st_q.activePre    <= 1'b0;
			st_q.svc          <= SVC_IDLE;
			st_q.wdCnt        <= '0;
			st_q.preCnt       <= '0;
			st_q.xdCnt        <= '0;
			st_q.irq          <= 1'b0;
			st_q.rstReq       <= 1'b0;
			st_q.bmCnt        <= '0;
			st_q.berr         <= 1'b0;
			st_q.rdData       <= 8'h00;
			st_q.modeA        <= st_d.modeA;
			st_q.modeB        <= st_d.modeB;
			st_q.slowDiv      <= 1'b0;
			st_q.strapPending <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	logic dblFaultReq;
	assign dblFaultReq    = dblFaultSeen & st_q.ctrl[PC_DBLF_ENABLE];
	assign dblFaultRstReq = dblFaultReq;
	assign clkLossRstReq  = clkLossRst & clock_loss_reset_enable & oscLoopEnable;
	assign regRdData      = st_q.rdData;
	assign irqVector      = st_q.vector;
	assign wdogIrqL7      = st_q.irq;
	assign wdogRstReq     = st_q.rstReq;
	assign busError       = st_q.berr;
endmodule // sprs_protect

// *** sprs_partner.sv ***
// Partner model: reset sources, reset completion and the crystal tick.
// Assumes the bench raises request bits for one cycle just after a rising edge.
module sprs_partner (
	input  wire logic       clk_sys,  // System clock.
	input  wire logic [6:0] evtReq,   // Bit 0 soft pin .. bit 5 power-on, bit 6 done.
	output logic      [6:0] evtPulse, // One-cycle event pulses.
	output logic            xtalTick  // Crystal tick on every other clock.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] pulse_q = 7'h00;
	logic       tick_q  = 1'b0;
	always @(posedge clk_sys) begin
		pulse_q <= evtReq;
		tick_q <= !tick_q;
	end
	assign evtPulse = pulse_q;
	assign xtalTick = tick_q;
endmodule // sprs_partner

// *** sprs_protect_chk.sv ***
// Checker for the protection block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
module sprs_chk
	import sprs_pkg::*;
(
	input wire logic       clk_sys,                 // Clock.
	input wire logic       sys_rst,                 // Reset.
	input wire logic [3:0] regAddr,                 // Address.
	input wire logic [7:0] regWrData,               // Write data.
	input wire logic       regWrite,                // Write strobe.
	input wire logic       regRead,                 // Read strobe.
	input wire logic [7:0] regRdData,               // Read data.
	input wire logic [7:0] irqVector,               // Vector.
	input wire logic       irqAck,                  // Acknowledge.
	input wire logic       wdogIrqL7,               // Interrupt.
	input wire logic       wdogRstReq,              // Reset request.
	input wire logic       busError,                // Bus error.
	input wire logic       extCycleActive,          // Cycle active.
	input wire logic       extCycleDone,            // Cycle done.
	input wire logic       dblFaultSeen,            // Double fault.
	input wire logic       dblFaultRstReq,          // Fault request.
	input wire logic       clkLossRstReq,           // Loss request.
	input wire logic       clock_loss_reset_enable, // Loss enable.
	input wire logic       oscLoopEnable            // Loop enable.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [10:0] busy_q;
	// Clocks of the current unterminated cycle; no bus error may come before the shortest timeout.
	always_ff @(posedge clk_sys) begin
		busy_q <= (sys_rst || !extCycleActive || extCycleDone) ? 11'h000 : busy_q + 11'h001;
	end
	AST_SVC_READ_ZERO: assert property (regRead && regAddr == OFF_WDOG_SERVICE |=> regRdData == 8'h00)
		else $error("service register read back nonzero");
	AST_VEC_WRITE: assert property (regWrite && regAddr == OFF_WDOG_VECTOR |=> irqVector == $past(regWrData))
		else $error("vector write not taken");
	AST_VEC_HOLD: assert property (!(regWrite && regAddr == OFF_WDOG_VECTOR) |=> $stable(irqVector))
		else $error("vector changed without a write");
	AST_ACK_CLEARS: assert property (irqAck |=> !wdogIrqL7)
		else $error("interrupt stayed after acknowledge");
	AST_RST_PULSE: assert property (wdogRstReq |=> !wdogRstReq)
		else $error("watchdog reset request longer than one cycle");
	AST_IRQ_NOT_RST: assert property ($rose(wdogIrqL7) |-> !wdogRstReq)
		else $error("interrupt and reset on one expiry");
	AST_BUSERR_PULSE: assert property (busError |=> !busError)
		else $error("bus error longer than one cycle");
	AST_BUSERR_LATE: assert property (busError |-> busy_q >= 11'h080)
		else $error("bus error before the shortest timeout");
	AST_CLKLOSS_GATE: assert property (clkLossRstReq |-> clock_loss_reset_enable && oscLoopEnable)
		else $error("clock loss reset while not enabled");
	AST_DBF_CAUSE: assert property (dblFaultRstReq |-> dblFaultSeen)
		else $error("double fault reset without a fault");
	cover property ($rose(wdogIrqL7));
	cover property (wdogRstReq);
	cover property (busError);
	cover property (dblFaultRstReq);
endmodule // sprs_chk

bind sprs_protect sprs_chk u_chk (.*);

// *** sprs_protect_tb_top.sv ***
// Bench for the protection block: register port, reset causes, watchdog, monitors.
// Assumes the partner model supplies reset events and the crystal tick.
module sprs_protect_tb_top
	import sprs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, lossEn = 1'b0, xtalTick;
	logic       loopEn = 1'b0;
	logic [1:0] modePins = 2'b00;
	logic       cycAct = 1'b0, cycDone = 1'b0, irqAck = 1'b0, dblSeen = 1'b0;
	logic       wdogIrqL7, wdogRstReq, dblReq, lossReq, busError;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00, regRdData, irqVector;
	logic [6:0] evtReq = 7'h00, evt;
	int         fails = 0, comparisons = 0;
	wire  [4:0] outs = {busError, dblReq, wdogRstReq, wdogIrqL7, lossReq};
	sprs_partner u_partner (.clk_sys(clk_sys), .evtReq(evtReq), .evtPulse(evt), .xtalTick(xtalTick));
	sprs_protect u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .xtalTick(xtalTick),
		.clock_mode_pins(modePins), .rstDone(evt[6]), .powerOnRst(evt[5]), .hardRst(evt[4]), .dblFaultRst(evt[3]),
		.clkLossRst(evt[2]), .clock_loss_reset_enable(lossEn), .oscLoopEnable(loopEn), .rstInstrRst(evt[1]),
		.cpuDisabled(1'b0), .softPinRst(evt[0]), .dblFaultSeen(dblSeen), .extCycleActive(cycAct),
		.extCycleDone(cycDone), .irqAck(irqAck), .irqVector(irqVector), .wdogIrqL7(wdogIrqL7),
		.wdogRstReq(wdogRstReq), .dblFaultRstReq(dblReq), .clkLossRstReq(lossReq), .busError(busError));
	initial begin
		forever #10 clk_sys = !clk_sys;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpN(input int n, input int lo, input int hi);
		comparisons++;
		if (n < lo || n > hi) begin
			fails++;
			$display("mismatch at %0t: count %h expected %h..%h", $time, n, lo, hi);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		cmp(regRdData, exp);
	endtask
	task automatic pulse(input logic [6:0] e);
		@(posedge clk_sys);
		evtReq <= e;
		@(posedge clk_sys);
		evtReq <= 7'h00;
		@(negedge clk_sys);
		cmp({7'h00, lossReq}, {7'h00, e[2] & lossEn & loopEn});
		repeat (3) @(posedge clk_sys);
	endtask
	// Bounded wait on one design output; n equals lim when it never came.
	task automatic waitFor(input int b, input int lim, output int n);
		n = 0;
		@(negedge clk_sys);
		while (outs[b] !== 1'b1 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic service();
		wr(OFF_WDOG_SERVICE, 8'h55);
		wr(OFF_WDOG_SERVICE, 8'hAA);
	endtask
	task automatic sysReset();
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
	endtask
	// Selectors for setLevel; one task drives six level inputs just after a rising edge.
	localparam int SL_ACK = 0, SL_CYC = 1, SL_DONE = 2, SL_DBL = 3, SL_LOSS = 4, SL_LOOP = 5;
	task automatic setLevel(input int sel, input logic v);
		@(posedge clk_sys);
		case (sel)
			SL_ACK:  irqAck <= v;
			SL_CYC:  cycAct <= v;
			SL_DONE: cycDone <= v;
			SL_DBL:  dblSeen <= v;
			SL_LOSS: lossEn <= v;
			default: loopEn <= v;
		endcase
	endtask
	task automatic t_reset();
		rd(OFF_PROT_CONTROL, 8'hFC);
		rd(OFF_WDOG_PRESCALE, 8'h01);
		rd(OFF_WDOG_VECTOR, 8'h0F);
		rd(OFF_WDOG_SERVICE, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		$display("test reset values done");
	endtask
	task automatic t_causes();
		logic [7:0] exp [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80};
		setLevel(SL_LOSS, 1'b1);
		setLevel(SL_LOOP, 1'b1);
		pulse(7'h20);
		pulse(7'h40);
		rd(OFF_RESET_CAUSE, 8'hC0);
		wr(OFF_RESET_CAUSE, 8'h40);
		rd(OFF_RESET_CAUSE, 8'h80);
		wr(OFF_RESET_CAUSE, 8'h00);
		rd(OFF_RESET_CAUSE, 8'h80);
		wr(OFF_RESET_CAUSE, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			pulse(7'(1 << i));
			rd(OFF_RESET_CAUSE, 8'h00);
			pulse(7'h40);
			rd(OFF_RESET_CAUSE, exp[i]);
			wr(OFF_RESET_CAUSE, exp[i]);
		end
		setLevel(SL_LOOP, 1'b0);
		pulse(7'h04);
		pulse(7'h40);
		rd(OFF_RESET_CAUSE, 8'h00);
		setLevel(SL_LOSS, 1'b0);
		setLevel(SL_LOOP, 1'b1);
		pulse(7'h04);
		pulse(7'h40);
		rd(OFF_RESET_CAUSE, 8'h00);
		$display("test reset causes done");
	endtask
	task automatic t_guard();
		int n;
		wr(OFF_PROT_CONTROL, 8'h8B);
		wr(OFF_PROT_CONTROL, 8'hFF);
		rd(OFF_PROT_CONTROL, 8'h8B);
		wr(OFF_WDOG_VECTOR, 8'hA5);
		wr(OFF_WDOG_PRESCALE, 8'h00);
		service();
		repeat (500) @(posedge clk_sys);
		// A lone second value, or a first value disarmed by a stray write, must not restart the count.
		wr(OFF_WDOG_SERVICE, 8'hAA);
		wr(OFF_WDOG_SERVICE, 8'h55);
		wr(OFF_WDOG_SERVICE, 8'h12);
		wr(OFF_WDOG_SERVICE, 8'hAA);
		waitFor(1, 1200, n);
		cmpN(n, 510, 520);
		cmp(irqVector, 8'hA5);
		setLevel(SL_ACK, 1'b1);
		setLevel(SL_ACK, 1'b0);
		@(negedge clk_sys);
		cmp({7'h00, wdogIrqL7}, 8'h00);
		setLevel(SL_CYC, 1'b1);
		waitFor(4, 300, n);
		cmpN(n, 126, 131);
		setLevel(SL_CYC, 1'b0);
		setLevel(SL_CYC, 1'b1);
		waitFor(4, 100, n);
		cmpN(n, 100, 100);
		setLevel(SL_DONE, 1'b1);
		cycAct <= 1'b0;
		setLevel(SL_DONE, 1'b0);
		setLevel(SL_DBL, 1'b1);
		waitFor(3, 8, n);
		cmpN(n, 0, 7);
		setLevel(SL_DBL, 1'b0);
		$display("test interrupt and monitors done");
	endtask
	task automatic t_action();
		int n;
		sysReset();
		rd(OFF_WDOG_VECTOR, 8'h0F);
		wr(OFF_PROT_CONTROL, 8'hCC);
		wr(OFF_WDOG_PRESCALE, 8'h00);
		service();
		waitFor(2, 1100, n);
		cmpN(n, 1016, 1032);
		cmp({7'h00, wdogIrqL7}, 8'h00);
		pulse(7'h40);
		rd(OFF_RESET_CAUSE, 8'h20);
		setLevel(SL_CYC, 1'b1);
		waitFor(4, 200, n);
		cmpN(n, 200, 200);
		setLevel(SL_CYC, 1'b0);
		$display("test reset action done");
	endtask
	task automatic t_disabled();
		int n;
		@(posedge clk_sys);
		modePins <= 2'b10;
		sysReset();
		rd(OFF_WDOG_PRESCALE, 8'h00);
		wr(OFF_PROT_CONTROL, 8'h00);
		wr(OFF_WDOG_PRESCALE, 8'h00);
		service();
		setLevel(SL_DBL, 1'b1);
		waitFor(3, 8, n);
		cmpN(n, 8, 8);
		setLevel(SL_DBL, 1'b0);
		setLevel(SL_CYC, 1'b1);
		waitFor(4, 1100, n);
		cmpN(n, 1020, 1030);
		setLevel(SL_CYC, 1'b0);
		waitFor(1, 1200, n);
		cmpN(n, 1200, 1200);
		$display("test disabled monitors done");
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_causes();
		t_guard();
		t_action();
		t_disabled();
		end_of_test();
	end
	initial begin
		#400us;
		fails++;
		end_of_test();
	end
endmodule // sprs_protect_tb_top
